//--- pkg/irq_priority_pkg.sv
// Constants, tables and types for the upper interrupt priority bank.
// Assumes a 32-bit AXI4-Lite register bus and one priority field per source.
package irq_priority_pkg;

    // sizes of the bank and of the bus
    localparam int NUM_SRC = 18;
    localparam int NUM_REG = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PRIO_W = 3;
    localparam int VIEW_W = 16;

    // priority codes
    localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;
    localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;
    localparam logic [PRIO_W-1:0] PRIO_MIN = 3'h1;
    localparam logic [PRIO_W-1:0] PRIO_MAX = 3'h7;

    // byte offsets: irq_priority_18, 19, 20, 21, 22, 23, 25, 26
    localparam logic [ADDR_W-1:0] REG_OFFSET [NUM_REG] = '{
        8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C
    };

    // implemented bits of each register, everything else reads zero
    localparam logic [VIEW_W-1:0] REG_MASK [NUM_REG] = '{
        16'h0007, 16'h7770, 16'h7770, 16'h7700,
        16'h0077, 16'h0077, 16'h7007, 16'h0777
    };

    // register index of each source field
    localparam logic [2:0] SRC_REG [NUM_SRC] = '{
        3'h0,                   // hlvd_prio
        3'h1, 3'h1, 3'h1,       // dac2_prio, dac1_prio, charge_time_prio
        3'h2, 3'h2, 3'h2,       // uart3_tx_prio, uart3_rx_prio, uart3_err_prio
        3'h3, 3'h3,             // uart4_err_prio, usb_ctrl_prio
        3'h4, 3'h4,             // uart4_tx_prio, uart4_rx_prio
        3'h5, 3'h5,             // capture9_prio, compare9_prio
        3'h6, 3'h6,             // opamp1_prio, lcd_ctrl_prio
        3'h7, 3'h7, 3'h7        // osc_selftune_prio, sigma_delta_prio, opamp2_prio
    };

    // low bit of each source field inside its register
    localparam logic [3:0] SRC_LSB [NUM_SRC] = '{
        4'h0,
        4'hC, 4'h8, 4'h4,
        4'hC, 4'h8, 4'h4,
        4'hC, 4'h8,
        4'h4, 4'h0,
        4'h4, 4'h0,
        4'hC, 4'h0,
        4'h8, 4'h4, 4'h0
    };

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // level and gated request handed to the arbiter
    typedef struct packed {
        logic [PRIO_W-1:0] level;
        logic req;
    } src_irq_t;

    typedef enum logic [1:0] {
        WR_COLLECT = 2'b01,
        WR_RESP = 2'b10
    } wr_state_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } rd_state_t;

endpackage : irq_priority_pkg

//--- rtl/irq_priority_bank.sv
// Upper interrupt priority bank: eight registers of 3-bit priority fields.
// Assumes an AXI4-Lite master on the clk domain and pending requests
// that arrive synchronous to clk; the arbiter sits downstream.
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps

module irq_priority_bank
    import irq_priority_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [NUM_SRC-1:0] srcPending,
    output src_irq_t [NUM_SRC-1:0] irqOut
);

    // write channel state
    wr_state_t wrState_reg;
    logic awready_reg;
    logic wready_reg;
    logic [ADDR_W-1:0] awAddr_reg;
    logic [VIEW_W-1:0] wData_reg;
    logic [1:0] wStrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;

    // read channel state
    rd_state_t rdState_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [1:0] rresp_reg;

    // priority fields and gated requests
    logic [PRIO_W-1:0] field_reg [NUM_SRC];
    logic [PRIO_W-1:0] field_next [NUM_SRC];
    logic [NUM_SRC-1:0] req_reg;
    logic [NUM_SRC-1:0] req_next;

    // decode
    logic [NUM_REG-1:0] wrHit;
    logic [NUM_REG-1:0] rdHit;
    logic wrMapped;
    logic rdMapped;
    logic awTake;
    logic wTake;
    logic arTake;
    logic doWrite;
    logic [NUM_SRC-1:0] fieldWe;
    logic [VIEW_W-1:0] regView [NUM_REG];
    logic [VIEW_W-1:0] rdWord;

    // handshakes and the write commit point
    assign awTake = awvalid && awready_reg;
    assign wTake = wvalid && wready_reg;
    assign arTake = arvalid && arready_reg;
    assign doWrite = (wrState_reg == WR_COLLECT) && !awready_reg && !wready_reg;

    // word decode against the offset table; low two address bits ignored
    generate
        for (genvar k = 0; k < NUM_REG; k++) begin : g_decode
            assign wrHit[k] = awAddr_reg[ADDR_W-1:2] == REG_OFFSET[k][ADDR_W-1:2];
            assign rdHit[k] = araddr[ADDR_W-1:2] == REG_OFFSET[k][ADDR_W-1:2];
        end
    endgenerate

    assign wrMapped = |wrHit;
    assign rdMapped = |rdHit;

    // per-source field: byte-lane gated write, gated request toward the arbiter
    generate
        for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
            assign fieldWe[s] = doWrite && wrHit[SRC_REG[s]]
                && (SRC_LSB[s][3] ? wStrb_reg[1] : wStrb_reg[0]);
            assign field_next[s] = fieldWe[s] ? wData_reg[SRC_LSB[s] +: PRIO_W]
                : field_reg[s];
            // a zero code blocks the request, any other code passes it
            assign req_next[s] = srcPending[s] && (field_reg[s] != PRIO_OFF);
            // level travels unchanged: its binary value is the priority
            assign irqOut[s].level = field_reg[s];
            assign irqOut[s].req = req_reg[s];

            // field storage, power-on level 4
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    field_reg[s] <= PRIO_RESET;
                end else begin
                    field_reg[s] <= field_next[s];
                end
            end

            property p_write_lands;
                @(posedge clk) disable iff (!rst_n)
                fieldWe[s] |=> field_reg[s] == $past(wData_reg[SRC_LSB[s] +: PRIO_W]);
            endproperty
            a_write_lands: assert property (p_write_lands)
                else $error("priority field did not take the written code");

            property p_hold_no_write;
                @(posedge clk) disable iff (!rst_n)
                !fieldWe[s] |=> $stable(field_reg[s]);
            endproperty
            a_hold_no_write: assert property (p_hold_no_write)
                else $error("priority field changed without a write");

            property p_disabled_no_req;
                @(posedge clk) disable iff (!rst_n)
                (field_reg[s] == PRIO_OFF) |=> !irqOut[s].req;
            endproperty
            a_disabled_no_req: assert property (p_disabled_no_req)
                else $error("disabled source raised a request");

            property p_enabled_req;
                @(posedge clk) disable iff (!rst_n)
                (rst_n && srcPending[s] && field_reg[s] >= PRIO_MIN) |=> irqOut[s].req;
            endproperty
            a_enabled_req: assert property (p_enabled_req)
                else $error("enabled pending source gave no request");

            property p_top_level;
                @(posedge clk) disable iff (!rst_n)
                (rst_n && srcPending[s] && field_reg[s] == PRIO_MAX && !fieldWe[s])
                    |=> (irqOut[s].req && irqOut[s].level == PRIO_MAX);
            endproperty
            a_top_level: assert property (p_top_level)
                else $error("top code did not give level seven with a request");

            // no pending input, no request on the next edge
            property p_idle_no_req;
                @(posedge clk) disable iff (!rst_n)
                !srcPending[s] |=> !irqOut[s].req;
            endproperty
            a_idle_no_req: assert property (p_idle_no_req)
                else $error("request raised without a pending input");
        end
    endgenerate

    // gated request flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_reg <= '0;
        end else begin
            req_reg <= req_next;
        end
    end

    // register views: fields placed at their bit positions, the rest zero
    always_comb begin
        for (int k = 0; k < NUM_REG; k++) begin
            regView[k] = '0;
            for (int s = 0; s < NUM_SRC; s++) begin
                if (SRC_REG[s] == 3'(k)) begin
                    regView[k][SRC_LSB[s] +: PRIO_W] = field_reg[s];
                end
            end
        end
    end

    // read data select
    always_comb begin
        rdWord = '0;
        for (int k = 0; k < NUM_REG; k++) begin
            if (rdHit[k]) begin
                rdWord = regView[k];
            end
        end
    end

    // write address and data taken in either order, then one response
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrState_reg <= WR_COLLECT;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            awAddr_reg <= '0;
            wData_reg <= '0;
            wStrb_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else begin
            case (wrState_reg)
                WR_COLLECT: begin
                    if (awTake) begin
                        awAddr_reg <= awaddr;
                        awready_reg <= 1'b0;
                    end
                    if (wTake) begin
                        wData_reg <= wdata[VIEW_W-1:0];
                        wStrb_reg <= wstrb[1:0];
                        wready_reg <= 1'b0;
                    end
                    if (doWrite) begin
                        bvalid_reg <= 1'b1;
                        bresp_reg <= wrMapped ? RESP_OKAY : RESP_SLVERR;
                        wrState_reg <= WR_RESP;
                    end
                end
                WR_RESP: begin
                    if (bready) begin
                        bvalid_reg <= 1'b0;
                        awready_reg <= 1'b1;
                        wready_reg <= 1'b1;
                        wrState_reg <= WR_COLLECT;
                    end
                end
                default: begin
                    wrState_reg <= WR_COLLECT;
                    awready_reg <= 1'b1;
                    wready_reg <= 1'b1;
                    bvalid_reg <= 1'b0;
                end
            endcase
        end
    end

    // read: address taken in idle, data held until accepted
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdState_reg <= RD_IDLE;
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else begin
            case (rdState_reg)
                RD_IDLE: begin
                    if (arTake) begin
                        rdata_reg <= {{(DATA_W - VIEW_W){1'b0}}, rdWord};
                        rresp_reg <= rdMapped ? RESP_OKAY : RESP_SLVERR;
                        rvalid_reg <= 1'b1;
                        arready_reg <= 1'b0;
                        rdState_reg <= RD_DATA;
                    end
                end
                RD_DATA: begin
                    if (rready) begin
                        rvalid_reg <= 1'b0;
                        arready_reg <= 1'b1;
                        rdState_reg <= RD_IDLE;
                    end
                end
                default: begin
                    rdState_reg <= RD_IDLE;
                    arready_reg <= 1'b1;
                    rvalid_reg <= 1'b0;
                end
            endcase
        end
    end

    // bus outputs straight from flops
    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;

    // read-back and unused-bit checks per register
    generate
        for (genvar k = 0; k < NUM_REG; k++) begin : g_reg_chk
            property p_unimpl_zero;
                @(posedge clk) disable iff (!rst_n)
                (arTake && rdHit[k]) |=> (rvalid_reg
                    && (rdata_reg[VIEW_W-1:0] & ~REG_MASK[k]) == '0
                    && rdata_reg[DATA_W-1:VIEW_W] == '0);
            endproperty
            a_unimpl_zero: assert property (p_unimpl_zero)
                else $error("unimplemented bits read non-zero");

            property p_read_back;
                @(posedge clk) disable iff (!rst_n)
                (arTake && rdHit[k]) |=> (rdata_reg[VIEW_W-1:0] == $past(regView[k])
                    && rresp_reg == RESP_OKAY) ##1 (rvalid_reg || $past(rready));
            endproperty
            a_read_back: assert property (p_read_back)
                else $error("read data does not match the register fields");
        end
    endgenerate

    property p_write_resp;
        @(posedge clk) disable iff (!rst_n)
        doWrite |=> (bvalid_reg && bresp_reg == ($past(wrMapped) ? RESP_OKAY : RESP_SLVERR));
    endproperty
    a_write_resp: assert property (p_write_resp)
        else $error("write response missing or wrong one cycle after commit");

    // a busy write channel refuses new address and data and keeps its response up
    property p_write_busy;
        @(posedge clk) disable iff (!rst_n)
        (wrState_reg == WR_RESP) |-> (bvalid_reg && !awready_reg && !wready_reg);
    endproperty
    a_write_busy: assert property (p_write_busy)
        else $error("write channel took a new request while a response was pending");

    // a busy read channel refuses a new address and keeps its data up
    property p_read_busy;
        @(posedge clk) disable iff (!rst_n)
        (rdState_reg == RD_DATA) |-> (rvalid_reg && !arready_reg);
    endproperty
    a_read_busy: assert property (p_read_busy)
        else $error("read channel took a new address while data was pending");

    // unmapped reads return zero with an error response
    property p_read_unmapped;
        @(posedge clk) disable iff (!rst_n)
        (arTake && !rdMapped) |=> (rdata_reg == '0 && rresp_reg == RESP_SLVERR);
    endproperty
    a_read_unmapped: assert property (p_read_unmapped)
        else $error("unmapped read gave data or an okay response");

endmodule : irq_priority_bank

//--- bench/irq_priority_bank_bench.sv
// Self-checking bench for the upper interrupt priority bank.
// Drives the AXI4-Lite port and the pending inputs itself; no partner model.
`timescale 1ns/1ps

module irq_priority_bank_bench
    import irq_priority_pkg::*;
();

    typedef struct {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [15:0] rback;
        logic [15:0] rstVal;
    } row_t;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic awready;
    logic [DATA_W-1:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic [ADDR_W-1:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic arready;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic [NUM_SRC-1:0] srcPending = '0;
    src_irq_t [NUM_SRC-1:0] irqOut;
    int fail_count = 0;
    int compares = 0;
    logic [1:0] resp;
    logic [DATA_W-1:0] rd;
    logic [2:0] lvlExp [NUM_SRC];

    // address, written word, read-back and reset value of each register
    row_t rows [NUM_REG] = '{
        '{8'h00, 32'hA5A5FFFD, 16'h0005, 16'h0004},
        '{8'h04, 32'hA5A5B6A3, 16'h3620, 16'h4440},
        '{8'h08, 32'hA5A59D7F, 16'h1570, 16'h4440},
        '{8'h0C, 32'hA5A572FF, 16'h7200, 16'h4400},
        '{8'h10, 32'hA5A5FF36, 16'h0036, 16'h0044},
        '{8'h14, 32'hA5A58841, 16'h0041, 16'h0044},
        '{8'h18, 32'hA5A5EFFB, 16'h6003, 16'h4004},
        '{8'h1C, 32'hA5A5FE5A, 16'h0652, 16'h0444}
    };
    // source levels that the written words above should give
    logic [2:0] rowLvl [NUM_SRC] = '{3'h5, 3'h3, 3'h6, 3'h2, 3'h1, 3'h5, 3'h7, 3'h7, 3'h2,
        3'h3, 3'h6, 3'h4, 3'h1, 3'h6, 3'h3, 3'h6, 3'h5, 3'h2};

    // clock, 8 ns period
    always #4 clk = ~clk;

    irq_priority_bank i_irq_priority_bank (.clk(clk), .rst_n(rst_n), .awaddr(awaddr),
        .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(1'b1),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(1'b1), .srcPending(srcPending),
        .irqOut(irqOut));

    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        compares++;
        if (seen !== expd) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%0h expected=%0h", $time, seen, expd);
        end
    endtask : check

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    // write: offer address and data together, release each when taken
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                            output logic [1:0] r);
        bit awDone;
        bit wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge clk);
            if (!awDone && awready) begin
                awDone = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wDone && wready) begin
                wDone = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (!bvalid);
        r = bresp;
    endtask : axiWrite

    // read: hold the request until taken, then wait for the data beat
    task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        d = rdata;
        r = rresp;
    endtask : axiRead

    // compare every source's level with lvlExp and its request with rq
    task automatic checkSources(input logic [NUM_SRC-1:0] rq);
        for (int s = 0; s < NUM_SRC; s++) begin
            check({29'h0, irqOut[s].level}, {29'h0, lvlExp[s]});
            check({31'h0, irqOut[s].req}, {31'h0, rq[s]});
        end
    endtask : checkSources

    task automatic setLevels(input logic [2:0] v);
        for (int s = 0; s < NUM_SRC; s++) begin
            lvlExp[s] = v;
        end
    endtask : setLevels

    // hang guard, far beyond the 140 or so cycles the tests need
    initial begin
        #(20000 * 8);
        fail_count++;
        complete_run();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        setLevels(PRIO_RESET);
        checkSources('0);
        srcPending <= '1;
        repeat (2) @(posedge clk);
        checkSources('1);
        // reset value, then all ones to expose every implemented bit
        for (int i = 0; i < NUM_REG; i++) begin
            axiRead(rows[i].addr, rd, resp);
            check(rd, {16'h0, rows[i].rstVal});
            axiWrite(rows[i].addr, 32'hFFFFFFFF, 4'hF, resp);
            check({30'h0, resp}, {30'h0, RESP_OKAY});
            axiRead(rows[i].addr, rd, resp);
            check(rd, {16'h0, rows[i].rstVal | rows[i].rstVal >> 1 | rows[i].rstVal >> 2});
        end
        setLevels(PRIO_MAX);
        checkSources('1);
        $display("test reset and masks done");
        // distinct codes per field locate each field in its register
        for (int i = 0; i < NUM_REG; i++) begin
            axiWrite(rows[i].addr, rows[i].wdata, 4'hF, resp);
            axiRead(rows[i].addr, rd, resp);
            check(rd, {16'h0, rows[i].rback});
            check({30'h0, resp}, {30'h0, RESP_OKAY});
        end
        lvlExp = rowLvl;
        checkSources('1);
        $display("test field placement done");
        // disable both channel 9 sources, clear only the low lane of register 19
        axiWrite(8'h14, 32'h0, 4'hF, resp);
        axiWrite(8'h04, 32'h0, 4'h1, resp);
        axiRead(8'h04, rd, resp);
        check(rd, 32'h00003600);
        lvlExp[3] = PRIO_OFF;
        lvlExp[11] = PRIO_OFF;
        lvlExp[12] = PRIO_OFF;
        repeat (2) @(posedge clk);
        checkSources(18'h3E7F7);
        $display("test disable and strobe done");
        // unmapped places refuse and store nothing
        axiWrite(8'h20, 32'hFFFFFFFF, 4'hF, resp);
        check({30'h0, resp}, {30'h0, RESP_SLVERR});
        axiRead(8'hFC, rd, resp);
        check({rd[29:0], resp}, {30'h0, RESP_SLVERR});
        axiRead(8'h1C, rd, resp);
        check(rd, 32'h00000652);
        // upper lane only: self-tune cleared, the low-lane fields kept
        axiWrite(8'h1C, 32'h0, 4'h2, resp);
        axiRead(8'h1C, rd, resp);
        check(rd, 32'h00000052);
        lvlExp[15] = PRIO_OFF;
        srcPending <= '0;
        repeat (2) @(posedge clk);
        checkSources('0);
        $display("test unmapped and release done");
        // second reset in mid-run restores level 4 everywhere
        srcPending <= '1;
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        setLevels(PRIO_RESET);
        checkSources('0);
        repeat (2) @(posedge clk);
        checkSources('1);
        axiRead(8'h08, rd, resp);
        check(rd, 32'h00004440);
        $display("test second reset done");
        complete_run();
    end

endmodule : irq_priority_bank_bench
